// ---- include/mds_pkg.sv ----
// constants, register map and carrier types of the multiply/divide/double-shift unit
// Overview of operation
// RULE1: opcode bits 15:9 select multiply (0111000), divide (0111001) or combined shift (0111011), bits 8:6 name R and bits 5:0 the source.
// RULE2: an even-R combined shift forms a 32-bit word with R high and R|1 low, shifts it arithmetically, loads C with the last bit out and sets V on a sign change.
// RULE3: the shift count is the low six bits of the source as a signed value from -32 to +31, positive shifting left and negative right.
// RULE4: an odd-R combined shift turns the right shift into a rotation of the single 16-bit register by the count.
// RULE5: an even-R multiply takes R and the source as two's complement and writes the 32-bit product to R and R|1.
// RULE6: an odd-R multiply writes only the low 16 bits of the product to R and drops the upper half.
// RULE7: after a multiply N shows a negative product and Z a zero product, each cleared otherwise.
// RULE8: after a multiply V is cleared and C is set only when the product does not fit a 16-bit signed value.
// RULE9: a divide divides the 32-bit two's complement dividend in R and R|1 by the 16-bit source.
// RULE10: a successful divide writes the quotient to R and gives a remainder with the sign of the dividend.
// RULE11: a successful divide writes the remainder to R|1.
// RULE12: software names an even R for every divide so that the register pair is valid.
// RULE13: after a divide N shows a negative quotient and Z a zero quotient, each cleared otherwise.
// RULE14: a divide sets V when the source is zero or when the quotient magnitude cannot fit.
// RULE15: a divide that sets V is aborted and writes no register.
// RULE16: a divide sets C only on a zero divisor and clears it otherwise.
`default_nettype none
package mds_pkg;
  // apb byte offsets
  localparam logic [7:0] MDS_OFS_INSTR = 8'h00;
  localparam logic [7:0] MDS_OFS_SRC = 8'h04;
  localparam logic [7:0] MDS_OFS_REG_R = 8'h08;
  localparam logic [7:0] MDS_OFS_REG_R1 = 8'h0c;
  localparam logic [7:0] MDS_OFS_CTRL = 8'h10;
  localparam logic [7:0] MDS_OFS_STATUS = 8'h14;
  localparam logic [7:0] MDS_OFS_RES_R = 8'h18;
  localparam logic [7:0] MDS_OFS_RES_R1 = 8'h1c;
  // ctrl fields
  localparam int MDS_CTRL_GO = 0;
  localparam int MDS_CTRL_CLR_DONE = 1;
  // opcode fields
  localparam int MDS_OP_HI = 15;
  localparam int MDS_OP_LO = 9;
  localparam int MDS_R_HI = 8;
  localparam int MDS_R_LO = 6;
  localparam logic [6:0] MDS_OP_MUL = 7'h38;
  localparam logic [6:0] MDS_OP_DIV = 7'h39;
  localparam logic [6:0] MDS_OP_SHC = 7'h3b;
  // shift count
  localparam int MDS_CNT_W = 6;
  localparam int MDS_WORD_W = 16;
  localparam int MDS_DBL_W = 32;
  localparam logic [15:0] MDS_RST_WORD = 16'h0000;
  // condition codes
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } mds_cc_t;
  // status register content, bits 11:0
  typedef struct packed {
    mds_cc_t cc;
    logic [2:0] rsvd;
    logic illegal;
    logic aborted;
    logic wr_r1;
    logic wr_r;
    logic done;
  } mds_status_t;
  localparam mds_status_t MDS_STATUS_RST = '0;
  // one execution result
  typedef struct packed {
    logic [15:0] res_r;
    logic [15:0] res_r1;
    mds_status_t st;
  } mds_result_t;
endpackage
`default_nettype wire

// ---- logic/mds_unit.sv ----
// multiply, divide and combined double shift datapath behind an apb register file
`default_nettype none
module mds_unit
  import mds_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RSTN,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR
);
  logic [15:0] instr_q;
  logic [15:0] src_q;
  logic [15:0] reg_r_q;
  logic [15:0] reg_r1_q;
  logic [15:0] res_r_q;
  logic [15:0] res_r1_q;
  mds_status_t status_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic wr_hit;
  logic go;
  logic clr_done;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic [15:0] wmask;
  mds_result_t res;

  // access phase completes only when our registered ready is high
  assign wr_hit = I_PSEL & I_PENABLE & pready_q & I_PWRITE;
  assign wmask = {{8{I_PSTRB[1]}}, {8{I_PSTRB[0]}}};
  assign go = wr_hit & (I_PADDR == MDS_OFS_CTRL) & I_PSTRB[0] & I_PWDATA[MDS_CTRL_GO];
  assign clr_done = wr_hit & (I_PADDR == MDS_OFS_CTRL) & I_PSTRB[0]
                    & I_PWDATA[MDS_CTRL_CLR_DONE];

  // read decode, unmapped offsets answer with an error
  always_comb begin
    rd_mux = '0;
    rd_ok = 1'b1;
    case (I_PADDR)
      MDS_OFS_INSTR: rd_mux[15:0] = instr_q;
      MDS_OFS_SRC: rd_mux[15:0] = src_q;
      MDS_OFS_REG_R: rd_mux[15:0] = reg_r_q;
      MDS_OFS_REG_R1: rd_mux[15:0] = reg_r1_q;
      MDS_OFS_CTRL: rd_mux = '0;
      MDS_OFS_STATUS: rd_mux[11:0] = status_q;
      MDS_OFS_RES_R: rd_mux[15:0] = res_r_q;
      MDS_OFS_RES_R1: rd_mux[15:0] = res_r1_q;
      default: rd_ok = 1'b0;
    endcase
  end

  // ready registered in the setup phase, no wait state, so that every apb output comes from a flop
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= I_PSEL & ~I_PENABLE;
      if (I_PSEL & ~I_PENABLE) begin
        prdata_q <= I_PWRITE ? 32'h0000_0000 : rd_mux;
        pslverr_q <= ~rd_ok;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  assign O_PREADY = pready_q;
  assign O_PRDATA = prdata_q;
  assign O_PSLVERR = pslverr_q;

  // operand words loaded by software over apb, one per offset
  mds_word_reg #(
    .OFS(MDS_OFS_INSTR)
  ) i_instr_reg (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_wr(wr_hit),
    .i_addr(I_PADDR),
    .i_data(I_PWDATA[MDS_WORD_W-1:0]),
    .i_mask(wmask),
    .o_word(instr_q)
  );

  mds_word_reg #(
    .OFS(MDS_OFS_SRC)
  ) i_src_reg (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_wr(wr_hit),
    .i_addr(I_PADDR),
    .i_data(I_PWDATA[MDS_WORD_W-1:0]),
    .i_mask(wmask),
    .o_word(src_q)
  );

  mds_word_reg #(
    .OFS(MDS_OFS_REG_R)
  ) i_reg_r_reg (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_wr(wr_hit),
    .i_addr(I_PADDR),
    .i_data(I_PWDATA[MDS_WORD_W-1:0]),
    .i_mask(wmask),
    .o_word(reg_r_q)
  );

  mds_word_reg #(
    .OFS(MDS_OFS_REG_R1)
  ) i_reg_r1_reg (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_wr(wr_hit),
    .i_addr(I_PADDR),
    .i_data(I_PWDATA[MDS_WORD_W-1:0]),
    .i_mask(wmask),
    .o_word(reg_r1_q)
  );

  // execution datapath, purely combinational on the operand registers
  logic [6:0] opc;
  logic r_odd;
  logic signed [5:0] cnt_s;
  logic [5:0] cnt_mag;
  logic [31:0] sh_v;
  logic [15:0] rot_w;
  logic sh_c;
  logic sh_vf;
  logic sign0;
  logic signed [31:0] prod;
  logic signed [31:0] dvd;
  logic signed [31:0] dvs;
  logic signed [31:0] quo;
  logic signed [31:0] rem;
  logic div_zero;
  logic div_ovf;
  logic prod_fits;
  logic quo_fits;
  // per-operation results, merged by opcode below
  mds_result_t mul_res;
  mds_result_t div_res;
  mds_result_t shc_res;

  assign opc = instr_q[MDS_OP_HI:MDS_OP_LO]; // RULE1
  assign r_odd = instr_q[MDS_R_LO]; // RULE1
  assign cnt_s = src_q[MDS_CNT_W-1:0]; // RULE3
  assign cnt_mag = cnt_s[MDS_CNT_W-1] ? 6'(-cnt_s) : 6'(cnt_s); // RULE3

  // bit-serial loop gives the last bit out and any sign change
  always_comb begin
    sh_v = (r_odd) ? {reg_r_q, reg_r_q} : {reg_r_q, reg_r1_q}; // RULE2
    rot_w = reg_r_q;
    sign0 = reg_r_q[MDS_WORD_W-1];
    sh_c = 1'b0;
    sh_vf = 1'b0;
    for (int i = 0; i < MDS_DBL_W; i++) begin
      if (6'(i) < cnt_mag) begin
        if (!cnt_s[MDS_CNT_W-1]) begin
          sh_c = sh_v[MDS_DBL_W-1]; // RULE2
          sh_v = {sh_v[MDS_DBL_W-2:0], 1'b0};
          if (sh_v[MDS_DBL_W-1] != sign0) begin
            sh_vf = 1'b1; // RULE2
          end
        end else if (!r_odd) begin
          sh_c = sh_v[0]; // RULE2
          sh_v = {sh_v[MDS_DBL_W-1], sh_v[MDS_DBL_W-1:1]};
        end else begin
          sh_c = rot_w[0]; // RULE4
          rot_w = {rot_w[0], rot_w[MDS_WORD_W-1:1]};
        end
      end
    end
  end

  // signed multiply and divide
  assign prod = $signed(reg_r_q) * $signed(src_q); // RULE5
  assign dvd = $signed({reg_r_q, reg_r1_q}); // RULE9
  assign dvs = 32'($signed(src_q)); // RULE9
  assign div_zero = (src_q == MDS_RST_WORD); // RULE14
  assign quo = div_zero ? 32'sh0 : dvd / dvs; // RULE9
  assign rem = div_zero ? 32'sh0 : dvd % dvs; // RULE10
  // the same fit check, instanced twice, serves the multiply carry and the divide overflow
  mds_fit_check i_prod_fit (
    .i_val(prod),
    .o_fits(prod_fits)
  );

  mds_fit_check i_quo_fit (
    .i_val(quo),
    .o_fits(quo_fits)
  );
  // a quotient outside 16-bit signed range means |R| too large for the source
  assign div_ovf = div_zero | ~quo_fits; // RULE14

  // multiply result, odd r keeps only the low product word
  always_comb begin
    mul_res = '0;
    mul_res.st.done = 1'b1;
    mul_res.res_r = r_odd ? prod[MDS_WORD_W-1:0] : prod[MDS_DBL_W-1:MDS_WORD_W]; // RULE5 RULE6
    mul_res.res_r1 = prod[MDS_WORD_W-1:0]; // RULE5
    mul_res.st.wr_r = 1'b1;
    mul_res.st.wr_r1 = ~r_odd; // RULE6
    mul_res.st.cc.n = prod[MDS_DBL_W-1]; // RULE7
    mul_res.st.cc.z = (prod == 32'sh0); // RULE7
    mul_res.st.cc.v = 1'b0; // RULE8
    mul_res.st.cc.c = ~prod_fits; // RULE8
  end

  // divide result; an abort leaves both registers unwritten
  always_comb begin
    div_res = '0;
    div_res.st.done = 1'b1;
    div_res.st.cc.v = div_ovf; // RULE14
    div_res.st.cc.c = div_zero; // RULE16
    div_res.st.aborted = div_ovf; // RULE15
    if (!div_ovf) begin
      div_res.res_r = quo[MDS_WORD_W-1:0]; // RULE10
      div_res.res_r1 = rem[MDS_WORD_W-1:0]; // RULE11
      div_res.st.wr_r = 1'b1;
      div_res.st.wr_r1 = 1'b1; // RULE11
      div_res.st.cc.n = quo[MDS_WORD_W-1]; // RULE13
      div_res.st.cc.z = (quo[MDS_WORD_W-1:0] == MDS_RST_WORD); // RULE13
    end
  end

  // shift result; for an odd r, n and z follow the word that lands in r
  always_comb begin
    shc_res = '0;
    shc_res.st.done = 1'b1;
    if (r_odd && cnt_s[MDS_CNT_W-1]) begin
      shc_res.res_r = rot_w; // RULE4
      shc_res.st.cc.n = rot_w[MDS_WORD_W-1]; // RULE4
      shc_res.st.cc.z = (rot_w == MDS_RST_WORD); // RULE4
    end else if (r_odd) begin
      shc_res.res_r = sh_v[MDS_WORD_W-1:0]; // RULE2
      shc_res.st.cc.n = sh_v[MDS_WORD_W-1];
      shc_res.st.cc.z = (sh_v[MDS_WORD_W-1:0] == MDS_RST_WORD);
    end else begin
      shc_res.res_r = sh_v[MDS_DBL_W-1:MDS_WORD_W]; // RULE2
      shc_res.st.cc.n = sh_v[MDS_DBL_W-1];
      shc_res.st.cc.z = (sh_v == 32'h0000_0000);
    end
    shc_res.res_r1 = sh_v[MDS_WORD_W-1:0]; // RULE2
    shc_res.st.wr_r = 1'b1;
    shc_res.st.wr_r1 = ~r_odd;
    shc_res.st.cc.v = sh_vf; // RULE2
    shc_res.st.cc.c = sh_c; // RULE2
  end

  // opcode picks one of the three results, anything else is flagged illegal
  always_comb begin
    res = '0;
    res.st.done = 1'b1;
    case (opc)
      MDS_OP_MUL: res = mul_res; // RULE1
      MDS_OP_DIV: res = div_res; // RULE1
      MDS_OP_SHC: res = shc_res; // RULE1
      default: res.st.illegal = 1'b1; // RULE1
    endcase
  end

  // results latch on go; a go in the same write as clear keeps done set
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      res_r_q <= MDS_RST_WORD;
      res_r1_q <= MDS_RST_WORD;
      status_q <= MDS_STATUS_RST;
    end else if (go) begin
      res_r_q <= res.res_r;
      res_r1_q <= res.res_r1;
      status_q <= res.st;
    end else if (clr_done) begin
      status_q.done <= 1'b0;
    end
  end
endmodule

// one 16-bit operand word with byte-lane strobes, written at the apb access edge
module mds_word_reg
  import mds_pkg::*;
#(
  parameter logic [7:0] OFS = MDS_OFS_INSTR
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // write side
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [MDS_WORD_W-1:0] i_data,
  input wire logic [MDS_WORD_W-1:0] i_mask,
  // stored word
  output logic [MDS_WORD_W-1:0] o_word
);
  logic [MDS_WORD_W-1:0] word_q;

  // lanes without a strobe keep their old bits
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      word_q <= MDS_RST_WORD;
    end else if (i_wr && (i_addr == OFS)) begin
      word_q <= (word_q & ~i_mask) | (i_data & i_mask);
    end
  end

  assign o_word = word_q;
endmodule

// tells whether a 32-bit two's complement value fits one signed 16-bit word
module mds_fit_check
  import mds_pkg::*;
(
  // value under test
  input wire logic [MDS_DBL_W-1:0] i_val,
  // verdict
  output logic o_fits
);
  logic [MDS_DBL_W-MDS_WORD_W:0] upper;

  // every bit above the word's sign must repeat that sign, else the value is cut
  assign upper = i_val[MDS_DBL_W-1:MDS_WORD_W-1];
  assign o_fits = (upper == {(MDS_DBL_W-MDS_WORD_W+1){i_val[MDS_WORD_W-1]}});
endmodule
`default_nettype wire

// ---- testbench/mds_unit_asserts.sv ----
// bus and result checks of the multiply/divide/double-shift unit
`default_nettype none
module mds_unit_asserts
  import mds_pkg::*;
(
  // watched ports
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  logic [6:0] op_q;
  logic rd_st;
  // last opcode written, so a status read can be judged per operation
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      op_q <= '0;
    end else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == MDS_OFS_INSTR) begin
      op_q <= I_PWDATA[MDS_OP_HI:MDS_OP_LO];
    end
  end
  assign rd_st = O_PREADY && !I_PWRITE && I_PADDR == MDS_OFS_STATUS;
  AST_READY_AFTER_SETUP: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("no ready after setup");
  AST_READY_IN_ACCESS: assert property (O_PREADY |-> I_PENABLE && $past(I_PSEL && !I_PENABLE))
    else $error("ready outside access");
  AST_ERR_UNMAPPED: assert property (O_PREADY && I_PADDR > 8'h1c |-> O_PSLVERR && O_PRDATA == '0)
    else $error("unmapped access not refused");
  AST_NO_ERR_MAPPED: assert property (O_PREADY && I_PADDR <= 8'h1c |-> !O_PSLVERR)
    else $error("mapped access refused");
  AST_MUL_V_CLEAR: assert property (rd_st && op_q == MDS_OP_MUL |-> !O_PRDATA[9])
    else $error("multiply left V set");
  AST_DIV_ABORT: assert property (rd_st && op_q == MDS_OP_DIV && O_PRDATA[3] |->
    O_PRDATA[11:9] == 3'h1 && O_PRDATA[2:1] == 2'h0) else $error("abort flags wrong");
  AST_DIV_C_ZERO: assert property (rd_st && op_q == MDS_OP_DIV && O_PRDATA[8] |->
    O_PRDATA[9] && O_PRDATA[3]) else $error("divide C without abort");
  AST_DIV_WRITES: assert property (rd_st && op_q == MDS_OP_DIV && !O_PRDATA[3] |->
    O_PRDATA[2:1] == 2'h3 && !O_PRDATA[9]) else $error("divide result not written");
endmodule
bind mds_unit mds_unit_asserts i_mds_unit_asserts (.I_CLK, .I_RSTN, .I_PSEL, .I_PENABLE,
  .I_PWRITE, .I_PADDR, .I_PWDATA, .I_PSTRB, .O_PRDATA, .O_PREADY, .O_PSLVERR);
`default_nettype wire

// ---- testbench/mds_rf_model.sv ----
// register file stand-in on the processor side of the unit
`default_nettype none
module mds_rf_model
  import mds_pkg::*;
(
  input wire logic i_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // cleared at start so that operands read back from it are never unknown
  logic [15:0] rf [8] = '{default: 16'h0000};
  // a divide always names an even pair
  function automatic logic [2:0] pick(input logic [2:0] r, input logic is_div);
    return is_div ? {r[2:1], 1'h0} : r;
  endfunction
  // only registers the model expects to be written are updated
  task automatic store(input logic [2:0] r, input mds_result_t x);
    if (x.st.wr_r) rf[r] = x.res_r;
    if (x.st.wr_r1) rf[r | 3'h1] = x.res_r1;
  endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench of the multiply/divide/double-shift unit
`default_nettype none
module testbench
  import mds_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, psel, pen, pwr, e, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, sd, rv;
  int fail_count, cmp_count, cyc;
  mds_unit i_mds_unit (.I_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'h3),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr));
  mds_rf_model i_mds_rf_model (.i_clk(clk));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // psel stays high between transfers so back-to-back setups follow at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    e = pslverr;
    pen <= 1'h0;
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // expected result of one operation
  function automatic mds_result_t model(logic [6:0] op, logic odd, logic [15:0] a, b, s);
    mds_result_t r;
    logic signed [63:0] p, q, m;
    logic [31:0] t;
    int n;
    r = '0;
    r.st.done = 1'h1;
    r.st.wr_r = 1'h1;
    r.st.wr_r1 = !odd;
    m = $signed({a, b});
    q = (s == 16'h0) ? 64'sh0 : m / $signed(s);
    p = (s == 16'h0) ? 64'sh0 : m % $signed(s);
    n = $signed(s[5:0]);
    t = {a, odd ? a : b};
    case (op)
      MDS_OP_MUL: begin
        p = $signed(a) * $signed(s);
        r.res_r = odd ? p[15:0] : p[31:16];
        r.res_r1 = p[15:0];
        r.st.cc = {p < 0, p == 0, 1'h0, p < -32768 || p > 32767};
      end
      MDS_OP_DIV: begin
        r.res_r = q[15:0];
        r.res_r1 = p[15:0];
        r.st.cc = {q < 0, q == 0, 2'h0};
        if (s == 16'h0 || q < -32768 || q > 32767) begin
          r.st = '0;
          r.st.done = 1'h1;
          r.st.aborted = 1'h1;
          r.st.cc = {3'h1, s == 16'h0};
        end
      end
      MDS_OP_SHC: begin
        for (int i = 0; i < (n < 0 ? -n : n); i++) begin
          r.st.cc.c = n > 0 ? t[31] : t[0];
          if (n > 0) t = t << 1;
          else t = odd ? {16'h0, t[0], t[15:1]} : {t[31], t[31:1]};
          r.st.cc.v |= n > 0 && t[31] != a[15];
        end
        r.res_r = odd ? t[15:0] : t[31:16];
        r.res_r1 = t[15:0];
        r.st.cc.n = odd ? t[15] : t[31];
        r.st.cc.z = odd ? t[15:0] == 16'h0 : t == 32'h0;
      end
      default: r.st = 12'h011;
    endcase
    return r;
  endfunction
  task automatic run(input logic [6:0] op, input logic [2:0] rn, input logic [15:0] a, b, s);
    mds_result_t x;
    x = model(op, rn[0], a, b, s);
    apb(1'h1, MDS_OFS_INSTR, {16'h0, op, rn, 6'h0});
    apb(1'h1, MDS_OFS_SRC, {16'h0, s});
    apb(1'h1, MDS_OFS_REG_R, {16'h0, a});
    apb(1'h1, MDS_OFS_REG_R1, {16'h0, b});
    apb(1'h1, MDS_OFS_CTRL, 32'h1);
    apb(1'h0, MDS_OFS_RES_R, 32'h0);
    if (x.st.wr_r) chk(rd, {16'h0, x.res_r});
    apb(1'h0, MDS_OFS_RES_R1, 32'h0);
    if (x.st.wr_r1) chk(rd, {16'h0, x.res_r1});
    apb(1'h0, MDS_OFS_STATUS, 32'h0);
    chk(rd, {20'h0, x.st});
    i_mds_rf_model.store(rn, x);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done;
    end
  end
  initial begin
    {rstn, psel, pen, pwr, paddr, pwdata} = '0;
    sd = 32'ha3cf;
    repeat (5) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    // zero divisor, overflowing quotient, negative remainder, extreme products and counts
    run(MDS_OP_DIV, 3'h2, 16'h1234, 16'h5678, 16'h0);
    run(MDS_OP_DIV, 3'h4, 16'h7fff, 16'hffff, 16'h1);
    run(MDS_OP_DIV, 3'h0, 16'hffff, 16'hfff9, 16'h2);
    run(MDS_OP_MUL, 3'h6, 16'h8000, 16'h0, 16'h8000);
    run(MDS_OP_MUL, 3'h3, 16'h8000, 16'h0, 16'h2);
    run(MDS_OP_SHC, 3'h2, 16'h4000, 16'h1, 16'h1f);
    run(MDS_OP_SHC, 3'h2, 16'h8000, 16'h0, 16'h20);
    run(MDS_OP_SHC, 3'h5, 16'h8001, 16'h0, 16'h3d);
    run(7'h3a, 3'h0, 16'h1, 16'h1, 16'h1);
    apb(1'h0, 8'h40, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'h0, MDS_OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    // clear of done alone, then clear together with go, where go must win
    apb(1'h1, MDS_OFS_CTRL, 32'h2);
    apb(1'h0, MDS_OFS_STATUS, 32'h0);
    chk(rd, 32'h10);
    apb(1'h1, MDS_OFS_CTRL, 32'h3);
    apb(1'h0, MDS_OFS_STATUS, 32'h0);
    chk(rd, 32'h11);
    repeat (150) begin
      sd = xs(sd);
      rv = xs(sd);
      rd = sd[1:0] == 2'h0 ? MDS_OP_MUL : sd[1:0] == 2'h1 ? MDS_OP_DIV : MDS_OP_SHC;
      // now and then the low operand word comes back from the register file
      run(rd[6:0], i_mds_rf_model.pick(sd[4:2], rd[6:0] == MDS_OP_DIV),
        sd[5] ? {16{rv[15]}} : sd[31:16],
        sd[6] ? i_mds_rf_model.rf[{sd[4:3], 1'h1}] : rv[15:0], rv[31:16]);
    end
    @(posedge clk);
    psel <= 1'h0;
    test_done;
  end
endmodule
`default_nettype wire
